// ---- rtl/rac_map.vh ----
// Register offsets, field positions and reset values of the alarm and power control block
`ifndef RAC_MAP_VH
`define RAC_MAP_VH
`define RAC_OFF_WINDOW 4'h0
`define RAC_OFF_ALARM_CFG 4'h1
`define RAC_OFF_CAL 4'h2
`define RAC_OFF_CTRL 4'h3
`define RAC_OFF_ALARM_SECMIN 4'h4
`define RAC_OFF_ALARM_HRWD 4'h5
`define RAC_OFF_ALARM_DAYMTH 4'h6
`define RAC_OFF_STATUS 4'h7
`define RAC_BIT_ALARM_ENABLE 15
`define RAC_BIT_REPEAT_FOREVER 14
`define RAC_MASK_HI 13
`define RAC_MASK_LO 10
`define RAC_CTRL_CLOCK_ENABLE 0
`define RAC_CTRL_WRITE_ENABLE 1
`define RAC_CTRL_OUTPUT_ENABLE 2
`define RAC_CTRL_SEL_LO 3
`define RAC_CTRL_POWER_ENABLE 5
`define RAC_CTRL_POLARITY 6
`define RAC_SEL_POWER 2'h3
`define RAC_SAMPLE_ALWAYS 8'hff
`define RAC_RESET_WORD 16'h0000
`define RAC_CAL_MULT 4
`endif

// ---- rtl/rac_alarm_power.v ----
// Alarm engine, calibration step, alarm pulse and power control window sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rac_map.vh"
module rac_alarm_power #(
	parameter ADDR_W = 4
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_b_in,
	// Register port
	input wire [ADDR_W-1:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [15:0] rdata_out,
	// Time base from the counters
	input wire [7:0] now_sec_in,
	input wire [7:0] now_min_in,
	input wire [7:0] now_hour_in,
	input wire [2:0] now_wday_in,
	input wire [7:0] now_day_in,
	input wire [7:0] now_month_in,
	input wire half_sec_tick_in,
	input wire sec_tick_in,
	input wire window_clk_in,
	// Wake-up events from the external device (pin)
	input wire wake_event_in,
	// Outputs
	output reg alarm_irq_out,
	output reg alarm_pulse_out,
	output reg cal_adjust_out,
	output reg [9:0] cal_amount_out,
	output reg wake_out,
	output reg power_pin_out,
	output reg power_pin_oe_out
);
	// Software visible registers
	reg [15:0] window_q;
	reg [15:0] alarm_cfg_q;
	reg [7:0] cal_q;
	reg [6:0] ctrl_q;
	reg [15:0] al_secmin_q;
	reg [15:0] al_hrwd_q;
	reg [15:0] al_daymth_q;
	// Pin synchronisers and edge history
	reg [2:0] wclk_sync_q;
	reg [1:0] wake_sync_q;
	// Window sequencer
	localparam ST_IDLE = 3'b001;
	localparam ST_STAB = 3'b010;
	localparam ST_SAMP = 3'b100;
	reg [2:0] state_q;
	reg [7:0] win_cnt_q;
	reg match_prev_q;
	reg [15:0] rd_mux;
	wire write_enable = ctrl_q[`RAC_CTRL_WRITE_ENABLE];
	wire clock_enable = ctrl_q[`RAC_CTRL_CLOCK_ENABLE];
	wire power_ctl_enable = ctrl_q[`RAC_CTRL_POWER_ENABLE];
	wire power_ctl_polarity = ctrl_q[`RAC_CTRL_POLARITY];
	wire alarm_enable = alarm_cfg_q[`RAC_BIT_ALARM_ENABLE];
	wire repeat_forever = alarm_cfg_q[`RAC_BIT_REPEAT_FOREVER];
	wire [3:0] alarm_mask = alarm_cfg_q[`RAC_MASK_HI:`RAC_MASK_LO];
	wire [7:0] stab_len = window_q[15:8];
	wire [7:0] samp_len = window_q[7:0];
	// Power control active only with every gate set
	wire pwc_on = clock_enable & power_ctl_enable & ctrl_q[`RAC_CTRL_OUTPUT_ENABLE] &
		(ctrl_q[`RAC_CTRL_SEL_LO+1:`RAC_CTRL_SEL_LO] == `RAC_SEL_POWER);
	// Rising edge of the synchronised window clock; first stage not read here
	wire wtick = wclk_sync_q[1] & ~wclk_sync_q[2];

	// Week and day both extend the daily match; month also needs the day
	// Compare digits under the mask; returns 1 when selected digits agree
	function digits_match;
		input [3:0] mask;
		input [15:0] a_sm, a_hw, a_dm;
		input [7:0] s, m, h;
		input [2:0] w;
		input [7:0] d, mo;
		reg ss, s1, mm, m1, hh, ww, dd, mt;
		begin
			s1 = (a_sm[3:0] == s[3:0]);
			ss = s1 & (a_sm[6:4] == s[6:4]);
			m1 = ss & (a_sm[11:8] == m[3:0]);
			mm = m1 & (a_sm[14:12] == m[6:4]);
			hh = mm & (a_hw[5:0] == h[5:0]);
			ww = hh & (a_hw[10:8] == w);
			dd = hh & (a_dm[5:0] == d[5:0]);
			mt = dd & (a_dm[12:8] == mo[4:0]);
			case (mask)
				4'h2: digits_match = s1;
				4'h3: digits_match = ss;
				4'h4: digits_match = m1;
				4'h5: digits_match = mm;
				4'h6: digits_match = hh;
				4'h7: digits_match = ww;
				4'h8: digits_match = dd;
				4'h9: digits_match = mt;
				default: digits_match = 1'b1;
			endcase
		end
	endfunction

	// Match is taken at the tick the mask asks for, once per equal interval
	wire raw_match = digits_match(alarm_mask, al_secmin_q, al_hrwd_q, al_daymth_q,
		now_sec_in, now_min_in, now_hour_in, now_wday_in, now_day_in, now_month_in);
	wire tick = (alarm_mask == 4'h0) ? half_sec_tick_in : sec_tick_in;
	// From mask 2 up only the first second of a matching span fires, so coarse masks do not repeat
	wire fire_ok = (alarm_mask < 4'h2) ? 1'b1 : ~match_prev_q;
	wire alarm_evt = alarm_enable & clock_enable & tick & raw_match & fire_ok;
	wire reg_wr_ok = wr_in & write_enable;
	// Software keeps calibration writes off the quarter-minute seconds; not policed here

	// Pin synchronisers
	// Third window stage only keeps history for the edge; logic never reads stage one
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			wclk_sync_q <= 3'h0;
			wake_sync_q <= 2'h0;
		end else begin
			wclk_sync_q <= {wclk_sync_q[1:0], window_clk_in};
			wake_sync_q <= {wake_sync_q[0], wake_event_in};
		end
	end

	// Register writes and hardware updates of the alarm configuration
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			window_q <= `RAC_RESET_WORD;
			alarm_cfg_q <= `RAC_RESET_WORD;
			cal_q <= 8'h00;
			ctrl_q <= 7'h00;
			al_secmin_q <= `RAC_RESET_WORD;
			al_hrwd_q <= `RAC_RESET_WORD;
			al_daymth_q <= `RAC_RESET_WORD;
			match_prev_q <= 1'b0;
		end else begin
			// History moves only on ticks, so a held time cannot retrigger
			if (tick)
				match_prev_q <= raw_match;
			if (wr_in && addr_in == `RAC_OFF_CTRL)
				ctrl_q <= wdata_in[6:0];
			if (wr_in && addr_in == `RAC_OFF_CAL)
				cal_q <= wdata_in[7:0];
			// Window timers need the write enable bit
			if (reg_wr_ok && addr_in == `RAC_OFF_WINDOW)
				window_q <= wdata_in;
			// Alarm value registers also gated by the write enable bit
			// Unused digit bits are dropped so they read back as zero
			if (reg_wr_ok && addr_in == `RAC_OFF_ALARM_SECMIN)
				al_secmin_q <= wdata_in & 16'h7f7f;
			if (reg_wr_ok && addr_in == `RAC_OFF_ALARM_HRWD)
				al_hrwd_q <= wdata_in & 16'h073f;
			if (reg_wr_ok && addr_in == `RAC_OFF_ALARM_DAYMTH)
				al_daymth_q <= wdata_in & 16'h1f3f;
			// Alarm event outranks a software write in the same cycle
			if (alarm_evt) begin
				if (alarm_cfg_q[7:0] != 8'h00)
					alarm_cfg_q[7:0] <= alarm_cfg_q[7:0] - 8'h01;
				else if (repeat_forever)
					alarm_cfg_q[7:0] <= 8'hff;
				else
					alarm_cfg_q[`RAC_BIT_ALARM_ENABLE] <= 1'b0;
			end else if (wr_in && addr_in == `RAC_OFF_ALARM_CFG) begin
				alarm_cfg_q <= wdata_in & 16'hfcff;
			end
		end
	end

	// Interrupt, alarm pulse and calibration step
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			alarm_irq_out <= 1'b0;
			alarm_pulse_out <= 1'b0;
			cal_adjust_out <= 1'b0;
			cal_amount_out <= 10'h000;
		end else begin
			alarm_irq_out <= alarm_evt;
			if (alarm_evt)
				alarm_pulse_out <= ~alarm_pulse_out;
			// Adjust applied on the minute rollover; amount is sign-extended times four
			cal_adjust_out <= clock_enable & sec_tick_in & (now_sec_in == 8'h00) &
				(cal_q != 8'h00);
			// Times four is a two-bit shift; ten bits keep the sign of the value
			cal_amount_out <= {cal_q, 2'b00};
		end
	end

	// Window sequencer: stability, then sample, each counted in window clocks
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			state_q <= ST_IDLE;
			win_cnt_q <= 8'h00;
		end else if (!pwc_on) begin
			// Losing any gate drops to idle; a cut window is not resumed
			state_q <= ST_IDLE;
			win_cnt_q <= 8'h00;
		end else if (alarm_evt) begin
			// Each alarm restarts from the stability window, or from the sample window when stab_len is zero
			if (stab_len != 8'h00) begin
				state_q <= ST_STAB;
				win_cnt_q <= stab_len;
			end else if (samp_len != 8'h00) begin
				state_q <= ST_SAMP;
				win_cnt_q <= samp_len;
			end else begin
				state_q <= ST_IDLE;
			end
		end else begin
			case (state_q)
				ST_STAB: begin
					if (wtick) begin
						if (win_cnt_q == 8'h01) begin
							state_q <= (samp_len != 8'h00) ? ST_SAMP : ST_IDLE;
							win_cnt_q <= samp_len;
						end else begin
							win_cnt_q <= win_cnt_q - 8'h01;
						end
					end
				end
				ST_SAMP: begin
					// All ones holds the window open
					if (wtick && samp_len != `RAC_SAMPLE_ALWAYS) begin
						if (win_cnt_q == 8'h01)
							state_q <= ST_IDLE;
						else
							win_cnt_q <= win_cnt_q - 8'h01;
					end
				end
				ST_IDLE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Sample window open, also always-open code regardless of enable
	wire samp_open = (state_q == ST_SAMP) | (samp_len == `RAC_SAMPLE_ALWAYS);
	wire pwr_active = pwc_on & (state_q != ST_IDLE);

	// Pin drive and wake-up gating
	always @(posedge clock_in) begin
		if (!rst_b_in) begin
			power_pin_out <= 1'b0;
			power_pin_oe_out <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			power_pin_out <= pwr_active ^ ~power_ctl_polarity;
			// Idle level is the inverse of the active level, so the switch stays off
			// Enable follows the gating only; with active low the pad may run open drain
			power_pin_oe_out <= pwc_on;
			wake_out <= wake_sync_q[1] & samp_open;
		end
	end

	// Read mux; unmapped addresses read zero
	// Status shows the sequencer state and count for debug
	always @* begin
		case (addr_in)
			`RAC_OFF_WINDOW: rd_mux = window_q;
			`RAC_OFF_ALARM_CFG: rd_mux = alarm_cfg_q;
			`RAC_OFF_CAL: rd_mux = {8'h00, cal_q};
			`RAC_OFF_CTRL: rd_mux = {9'h000, ctrl_q};
			`RAC_OFF_ALARM_SECMIN: rd_mux = al_secmin_q;
			`RAC_OFF_ALARM_HRWD: rd_mux = al_hrwd_q;
			`RAC_OFF_ALARM_DAYMTH: rd_mux = al_daymth_q;
			`RAC_OFF_STATUS: rd_mux = {5'h00, state_q, win_cnt_q};
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge clock_in) begin
		if (!rst_b_in)
			rdata_out <= 16'h0000;
		else
			rdata_out <= rd_in ? rd_mux : 16'h0000;
	end
endmodule
`default_nettype wire

// ---- dv/rac_ext_dev.sv ----
// Model of the external device switched by the power pin
`timescale 1ns/1ps
`default_nettype none
module rac_ext_dev #(
	parameter int WAKE_DLY = 4
) (
	// Pin side seen by the device
	input wire logic clock_in,
	input wire logic pin_in,
	input wire logic oe_in,
	input wire logic pol_in,
	// Wake line, pulled low while unpowered
	output logic wake_out
);
	int on_n = 0; // Cycles since supply came up
	initial wake_out = 1'b0;
	// Device needs a few cycles after power-up before it can raise a wake request
	always @(posedge clock_in) begin
		if (oe_in && pin_in == pol_in) begin
			on_n <= on_n + 1;
			wake_out <= on_n >= WAKE_DLY;
		end else begin
			on_n <= 0;
			wake_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- dv/rac_alarm_power_sva.sv ----
// Port checker of the alarm and power control block
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_power_sva (
	// Observed ports
	input wire clock_in, rst_b_in, rd_in, half_sec_tick_in, sec_tick_in, wake_event_in,
	input wire [7:0] now_sec_in,
	input wire alarm_irq_out, alarm_pulse_out, cal_adjust_out, wake_out,
	input wire [15:0] rdata_out,
	input wire [9:0] cal_amount_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// Strobes last one cycle
	sequence irq_once_s; alarm_irq_out ##1 !alarm_irq_out; endsequence
	sequence cal_once_s; cal_adjust_out ##1 !cal_adjust_out; endsequence
	irq_cause_a:
		assert property (alarm_irq_out |-> $past(half_sec_tick_in || sec_tick_in)
			|| $past(half_sec_tick_in || sec_tick_in, 2)) else $error("irq without tick");
	irq_once_a:
		assert property (alarm_irq_out |-> irq_once_s) else $error("irq too long");
	pulse_follow_a:
		assert property ($changed(alarm_pulse_out) |-> alarm_irq_out || $past(alarm_irq_out))
			else $error("pulse moved without alarm");
	cal_cause_a:
		assert property (cal_adjust_out |-> $past(sec_tick_in && now_sec_in == 8'h00))
			else $error("adjust off minute");
	cal_once_a:
		assert property (cal_adjust_out |-> cal_once_s) else $error("adjust too long");
	cal_scale_a:
		assert property (cal_adjust_out |-> cal_amount_out[1:0] == 2'h0) else $error("not x4");
	rdata_idle_a:
		assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("stray rdata");
	wake_cause_a:
		assert property ($rose(wake_out) |-> $past(wake_event_in, 2) || $past(wake_event_in, 3)
			|| $past(wake_event_in, 4)) else $error("wake without event");
endmodule
bind rac_alarm_power rac_alarm_power_sva u_sva (.*);
`default_nettype wire

// ---- dv/rac_alarm_power_bench.sv ----
// Self-checking bench of the alarm and power control block
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_power_bench;
	logic clock_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0, tick = 0, wclk = 0, pol = 0;
	logic [3:0] addr_in = 0;
	logic [15:0] wdata_in = 0, rd_v, rdata_out;
	logic [7:0] sec = 8'h01; // Seconds digits fed to the alarm compare
	logic [9:0] cal_seen = 0, cal_amt; // Last adjust amount seen
	logic irq, pulse, cal_adj, wake_ev, wake, pin, oe;
	int bad_count = 0, tests_run = 0, irq_n = 0, cyc = 0;
	always #12.5 clock_in = ~clock_in;
	rac_alarm_power uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.now_sec_in(sec), .now_min_in(8'h00), .now_hour_in(8'h00), .now_wday_in(3'h0),
		.now_day_in(8'h00), .now_month_in(8'h00), .half_sec_tick_in(tick),
		.sec_tick_in(tick), .window_clk_in(wclk), .wake_event_in(wake_ev),
		.alarm_irq_out(irq), .alarm_pulse_out(pulse), .cal_adjust_out(cal_adj),
		.cal_amount_out(cal_amt), .wake_out(wake), .power_pin_out(pin), .power_pin_oe_out(oe));
	rac_ext_dev dev (.clock_in(clock_in), .pin_in(pin), .oe_in(oe), .pol_in(pol),
		.wake_out(wake_ev));
	// Event counters and hang guard
	always @(posedge clock_in) begin
		cyc++;
		if (irq === 1'b1) irq_n++;
		if (cal_adj === 1'b1) cal_seen <= cal_amt;
		// The whole run needs well under a thousand cycles
		if (cyc == 2000) begin
			bad_count++;
			print_verdict;
		end
	end
	task chk(input [15:0] exp, got, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task chk1(input logic exp, got, input string what);
		chk({15'h0, exp}, {15'h0, got}, what);
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1;
		@(posedge clock_in);
		wr_in <= 0;
	endtask
	// Read data only stands in the cycle after the strobe
	task rc(input [3:0] a, input [15:0] exp, input string what);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1;
		@(posedge clock_in);
		rd_in <= 0;
		// Taken at the next edge, before the design clears it
		@(posedge clock_in);
		rd_v = rdata_out;
		chk(exp, rd_v, what);
	endtask
	task tk;
		@(posedge clock_in);
		tick <= 1;
		@(posedge clock_in);
		tick <= 0;
		repeat (3) @(posedge clock_in);
	endtask
	// Slow window clock; synchroniser latency covered by the tail wait
	task wc(input int n);
		repeat (n) begin
			repeat (3) @(posedge clock_in);
			wclk <= 1;
			repeat (3) @(posedge clock_in);
			wclk <= 0;
		end
		repeat (4) @(posedge clock_in);
	endtask
	task t_regs;
		rc(4'h0, 16'h0000, "window reset");
		rc(4'h1, 16'h0000, "alarm cfg reset");
		wr(4'h3, 16'h0001);
		wr(4'h0, 16'h1234);
		rc(4'h0, 16'h0000, "window locked");
		wr(4'h3, 16'h0003);
		wr(4'h0, 16'h1234);
		rc(4'h0, 16'h1234, "window open");
		wr(4'h4, 16'hffff);
		rc(4'h4, 16'h7f7f, "alarm sec min");
		wr(4'h5, 16'hffff);
		rc(4'h5, 16'h073f, "alarm wday hour");
		wr(4'h6, 16'hffff);
		rc(4'h6, 16'h1f3f, "alarm month day");
		wr(4'h4, 16'h0000);
		wr(4'h5, 16'h0000);
		wr(4'h6, 16'h0000);
		rc(4'hf, 16'h0000, "unmapped");
		$display("regs done");
	endtask
	// Match starts when seconds step to 00 after the alarm is armed
	task t_alarm(input [15:0] cfg, input int n, input [15:0] exp, input int fires);
		int b;
		b = irq_n;
		sec <= 8'h01;
		wr(4'h1, cfg);
		// Coarse masks only fire on a fresh match, so show them a miss first
		if (cfg[13:10] > 4'h1) tk;
		sec <= 8'h00;
		repeat (n) tk;
		chk(fires[15:0], 16'(irq_n - b), "alarm count");
		rc(4'h1, exp, "alarm cfg after");
		chk1(irq_n[0], pulse, "pulse level");
		$display("alarm %h done", cfg);
	endtask
	task t_pow(input logic p, input [1:0] s);
		pol <= p;
		wr(4'h0, 16'h0203);
		wr(4'h3, {9'h0, p, 1'b1, s, 3'h7});
		wr(4'h1, 16'hc400);
		tk;
		chk1(s == 2'h3, oe, "pin enable");
		wc(1);
		if (s == 2'h3) chk1(p, pin, "pin in stab");
		chk1(1'b0, wake, "wake in stab");
		wc(3);
		if (s == 2'h3) chk1(p, pin, "pin in sample");
		chk1(s == 2'h3, wake, "wake in sample");
		wc(1);
		if (s == 2'h3) chk1(~p, pin, "pin idle");
		chk1(1'b0, wake, "wake idle");
		wr(4'h1, 16'h0000);
		$display("power %b %h done", p, s);
	endtask
	// A second alarm inside the stability window starts it over
	task t_again;
		pol <= 1'b1;
		wr(4'h0, 16'h0203);
		wr(4'h3, 16'h007f);
		wr(4'h1, 16'hc400);
		tk;
		wc(1);
		tk;
		wc(1);
		chk1(1'b0, wake, "wake after restart");
		wc(1);
		chk1(1'b1, wake, "wake late sample");
		wr(4'h1, 16'h0000);
		wr(4'h3, 16'h0003);
		$display("restart done");
	endtask
	// Zero stability samples from the alarm; the all-ones code never closes
	task t_open;
		pol <= 1'b1;
		wr(4'h0, 16'h00ff);
		wr(4'h3, 16'h007f);
		wr(4'h1, 16'hc400);
		tk;
		wc(3);
		chk1(1'b1, pin, "pin held open");
		chk1(1'b1, wake, "wake held open");
		wr(4'h1, 16'h0000);
		wr(4'h3, 16'h0003);
		repeat (2) @(posedge clock_in);
		chk1(1'b0, oe, "pin released");
		$display("open window done");
	endtask
	// Calibration is written with the time base stopped
	task t_cal;
		wr(4'h3, 16'h0002);
		wr(4'h2, 16'h00ff);
		wr(4'h3, 16'h0003);
		tk;
		chk(16'h03fc, {6'h0, cal_seen}, "cal amount");
		wr(4'h3, 16'h0002);
		wr(4'h2, 16'h0000);
		$display("cal done");
	endtask
	task print_verdict;
		$display("checks %0d bad %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock_in);
		rst_b_in <= 1;
		t_regs;
		for (int m = 0; m < 10; m++) t_alarm(16'h8000 | 16'(m << 10), 1, 16'(m << 10), 1);
		t_alarm(16'h8400, 2, 16'h0400, 1);
		t_alarm(16'h8402, 4, 16'h0400, 3);
		t_alarm(16'hc400, 1, 16'hc4ff, 1);
		wr(4'h1, 16'h0000);
		t_pow(1'b1, 2'h3);
		t_pow(1'b0, 2'h3);
		t_pow(1'b1, 2'h2);
		t_again;
		t_open;
		t_cal;
		print_verdict;
	end
endmodule
`default_nettype wire
